// [sdm_pkg.sv]
// Contract
// [R01] Interpolator is third-order noise shaping; denominator any integer 2 through 4095.
// [R02] Host keeps the denominator at 50 or more while dither is on.
// [R03] Interpolator advances once per reference cycle; step is reference rate over denominator.
// [R04] Dither off: sequence repeats after 2, 3, 6 or 1 times denominator.
// [R05] Dither on: sequence repeat length is two to the twenty-first cycles.
// [R06] Restart bit zero: each integer/fraction write restarts and seeds from phase word.
// [R07] Phase resync is active only when clock divider bits 20:19 are one, zero.
// [R08] Resync timer pulses every divider value times denominator reference cycles.
// [R09] Divider value is bits 18:7 of clock divider register, valid 1 through 4095.
// [R10] Denominator for the timer comes from bits 14:3 of its register.
// [R11] Output phase realigns on the second sync pulse after load strobe rises.
// [R12] Host sets sync interval no shorter than worst-case loop settling time.
// [R13] Phase word steps output phase by 360 degrees over the denominator.
// [R14] One bit shifts in per serial clock rise; strobe rise latches selected word.
// [R15] Host keeps the serial clock at or below 20 MHz.
// [R16] Without a phase table, host holds the phase word constant.
// [R17] Low three bits select the register; one, zero, zero is the clock divider.
// [R18] Sync timer counts reference cycles and restarts at each strobe rise.
// [R19] Extra bits push out the oldest; latch holds the last 29 received.
package sdm_pkg;
	localparam int          WORD_W       = 29;
	localparam int          FIELD_W      = 12;
	localparam int          INT_W        = 13;
	localparam int          LFSR_W       = 21;
	localparam int          CNT_W        = 24;
	localparam int          ADDR_W       = 8;
	// Serial word destinations
	localparam logic [2:0]  SEL_INT_FRAC = 3'h0;
	localparam logic [2:0]  SEL_PHASE    = 3'h1;
	localparam logic [2:0]  SEL_DENOM    = 3'h2;
	localparam logic [2:0]  SEL_FUNC     = 3'h3;
	localparam logic [2:0]  SEL_CLKDIV   = 3'h4;
	// Field positions
	localparam int          FRAC_LSB     = 3;
	localparam int          INT_LSB      = 15;
	localparam int          PHASE_LSB    = 3;
	localparam int          DENOM_LSB    = 3;
	localparam int          RESTART_BIT  = 14;
	localparam int          CDIV_LSB     = 7;
	localparam int          MODE_LO      = 19;
	localparam logic [1:0]  MODE_RESYNC  = 2'h2;
	localparam logic [11:0] DENOM_MIN    = 12'h002;
	localparam logic [11:0] CDIV_MIN     = 12'h001;
	localparam logic [1:0]  PEND_START   = 2'h2;
	// Reset values
	localparam logic [28:0] WORD_RST     = 29'h000_0000;
	localparam logic [20:0] LFSR_RST     = 21'h0_0001;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	// Register offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_DIVIDE   = 8'h08;
	localparam logic [7:0]  OFS_WORD0    = 8'h0C;
	localparam logic [7:0]  OFS_WORD1    = 8'h10;
	localparam logic [7:0]  OFS_WORD2    = 8'h14;
	localparam logic [7:0]  OFS_WORD3    = 8'h18;
	localparam logic [7:0]  OFS_WORD4    = 8'h1C;
	localparam int          CTRL_DITHER  = 0;
endpackage

// [pin_sync3.sv]
`timescale 1ns/1ns
module pin_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin and settled level
	input  wire logic pin,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r  <= RST_VAL;
			s2_r  <= RST_VAL;
			s3_r  <= RST_VAL;
			level <= RST_VAL;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level <= s3_r;
		end
	end
endmodule

// [fractional_sdm_phase_resync.sv]
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module fractional_sdm_phase_resync (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial load port pins
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        load_strobe,
	// Phase comparator reference pin
	input  wire logic        phase_comparator_ref,
	// Divider control out
	output logic [12:0]      n_value,
	output logic [3:0]       interp_code,
	output logic             sync_tick,
	output logic             phase_realign
);
	logic        sclk_s;
	logic        sdata_s;
	logic        le_s;
	logic        ref_s;
	logic        sclk_d_r;
	logic        le_d_r;
	logic        ref_d_r;
	logic        sclk_rise;
	logic        le_rise;
	logic        ref_tick;
	logic [28:0] shift_r;
	logic [28:0] word0_r;
	logic [28:0] word1_r;
	logic [28:0] word2_r;
	logic [28:0] word3_r;
	logic [28:0] word4_r;
	logic        dither_en_r;
	logic [11:0] frac_f;
	logic [12:0] int_f;
	logic [11:0] phase_f;
	logic [11:0] denom_f;
	logic [11:0] denom_eff;
	logic [11:0] cdiv_f;
	logic [11:0] cdiv_eff;
	logic [11:0] seed_val;
	logic        restart_bit;
	logic        resync_on;
	logic        load_r0;
	logic        seed_now;
	logic [11:0] acc1_r;
	logic [11:0] acc2_r;
	logic [11:0] acc3_r;
	logic        c2d_r;
	logic        c3d_r;
	logic        c3dd_r;
	logic [12:0] st1;
	logic [12:0] st2;
	logic [12:0] st3;
	logic [11:0] inc1;
	logic [3:0]  code;
	logic [20:0] lfsr_r;
	logic [23:0] period;
	logic [23:0] sync_cnt_r;
	logic        sync_pulse;
	logic [1:0]  pend_r;
	logic        apb_wr;
	logic        mapped;
	logic [31:0] rdata;

	pin_sync3 #(.RST_VAL(1'b0)) u_sclk (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (sclk),
		.level   (sclk_s)
	);
	pin_sync3 #(.RST_VAL(1'b0)) u_sdata (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (sdata),
		.level   (sdata_s)
	);
	pin_sync3 #(.RST_VAL(1'b0)) u_le (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (load_strobe),
		.level   (le_s)
	);
	pin_sync3 #(.RST_VAL(1'b0)) u_ref (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (phase_comparator_ref),
		.level   (ref_s)
	);

	// Edge detection on settled pin levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_d_r <= 1'b0;
			le_d_r   <= 1'b0;
			ref_d_r  <= 1'b0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			le_d_r   <= le_s;
			ref_d_r  <= ref_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign le_rise   = le_s & ~le_d_r;
	assign ref_tick  = ref_s & ~ref_d_r; // R03

	// Serial shift register, newest bit at bit 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shift_r <= sdm_pkg::WORD_RST;
		else if (sclk_rise)
			shift_r <= {shift_r[27:0], sdata_s}; // R14 R19
	end

	// Word latches selected by the low three bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word0_r <= sdm_pkg::WORD_RST;
			word1_r <= sdm_pkg::WORD_RST;
			word2_r <= sdm_pkg::WORD_RST;
			word3_r <= sdm_pkg::WORD_RST;
			word4_r <= sdm_pkg::WORD_RST;
		end
		else if (le_rise)
		begin
			case (shift_r[2:0]) // R14 R17
				sdm_pkg::SEL_INT_FRAC: word0_r <= shift_r;
				sdm_pkg::SEL_PHASE:    word1_r <= shift_r;
				sdm_pkg::SEL_DENOM:    word2_r <= shift_r;
				sdm_pkg::SEL_FUNC:     word3_r <= shift_r;
				sdm_pkg::SEL_CLKDIV:   word4_r <= shift_r;
				default:               word0_r <= word0_r;
			endcase
		end
	end

	// Field extraction
	assign frac_f      = word0_r[sdm_pkg::FRAC_LSB +: sdm_pkg::FIELD_W];
	assign int_f       = word0_r[sdm_pkg::INT_LSB +: sdm_pkg::INT_W];
	assign phase_f     = word1_r[sdm_pkg::PHASE_LSB +: sdm_pkg::FIELD_W];
	assign denom_f     = word2_r[sdm_pkg::DENOM_LSB +: sdm_pkg::FIELD_W]; // R10
	assign cdiv_f      = word4_r[sdm_pkg::CDIV_LSB +: sdm_pkg::FIELD_W]; // R09
	assign restart_bit = word3_r[sdm_pkg::RESTART_BIT];
	assign resync_on   = (word4_r[sdm_pkg::MODE_LO +: 2] == sdm_pkg::MODE_RESYNC); // R07
	assign denom_eff   = (denom_f < sdm_pkg::DENOM_MIN) ? sdm_pkg::DENOM_MIN : denom_f; // R01
	assign cdiv_eff    = (cdiv_f < sdm_pkg::CDIV_MIN) ? sdm_pkg::CDIV_MIN : cdiv_f; // R09
	assign seed_val    = (phase_f >= denom_eff) ? 12'(phase_f - denom_eff) : phase_f; // R13
	assign load_r0     = le_rise && (shift_r[2:0] == sdm_pkg::SEL_INT_FRAC);
	assign seed_now    = (load_r0 && !restart_bit) || (sync_pulse && pend_r == 2'h1); // R06 R11

	// One accumulator stage modulo the denominator
	function automatic logic [12:0] acc_step(input logic [11:0] acc, input logic [11:0] inc,
		input logic [11:0] m);
		logic [12:0] s;
		s = {1'b0, acc} + {1'b0, inc};
		if (s >= {1'b0, m})
			acc_step = {1'b1, 12'(s - {1'b0, m})};
		else
			acc_step = {1'b0, s[11:0]};
	endfunction

	// Dither adds one pseudo-random lsb to the first stage
	assign inc1 = 12'(frac_f + {11'h000, dither_en_r & lfsr_r[0]}); // R05
	assign st1  = acc_step(acc1_r, inc1, denom_eff); // R01
	assign st2  = acc_step(acc2_r, st1[11:0], denom_eff);
	assign st3  = acc_step(acc3_r, st2[11:0], denom_eff);

	// Third-order error cancellation of the three carries
	always_comb
	begin
		code = $signed({3'b000, st1[12]}) + $signed({3'b000, st2[12]}) - $signed({3'b000, c2d_r})
			+ $signed({3'b000, st3[12]}) - $signed({2'b00, c3d_r, 1'b0}) + $signed({3'b000, c3dd_r}); // R01
	end

	// Maximal length 21-bit sequence for dither
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lfsr_r <= sdm_pkg::LFSR_RST;
		else if (seed_now)
			lfsr_r <= sdm_pkg::LFSR_RST;
		else if (ref_tick && dither_en_r)
			lfsr_r <= {lfsr_r[19:0], lfsr_r[20] ^ lfsr_r[18]}; // R05
	end

	// Modulator state, one step per reference cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc1_r <= 12'h000;
			acc2_r <= 12'h000;
			acc3_r <= 12'h000;
			c2d_r  <= 1'b0;
			c3d_r  <= 1'b0;
			c3dd_r <= 1'b0;
		end
		else if (seed_now)
		begin
			acc1_r <= seed_val; // R06 R13
			acc2_r <= 12'h000;
			acc3_r <= 12'h000;
			c2d_r  <= 1'b0;
			c3d_r  <= 1'b0;
			c3dd_r <= 1'b0;
		end
		else if (ref_tick)
		begin
			acc1_r <= st1[11:0]; // R03 R04
			acc2_r <= st2[11:0];
			acc3_r <= st3[11:0];
			c2d_r  <= st2[12];
			c3d_r  <= st3[12];
			c3dd_r <= c3d_r;
		end
	end

	// Divide value to the feedback divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			n_value     <= 13'h0000;
			interp_code <= 4'h0;
		end
		else if (ref_tick)
		begin
			n_value     <= int_f + {{9{code[3]}}, code}; // R03
			interp_code <= code;
		end
	end

	// Sync timer
	assign period     = {12'h000, cdiv_eff} * {12'h000, denom_eff}; // R08
	assign sync_pulse = resync_on && ref_tick && !le_rise && (sync_cnt_r == 24'(period - 24'h00_0001)); // R08

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_cnt_r <= 24'h00_0000;
		else if (le_rise)
			sync_cnt_r <= 24'h00_0000; // R18
		else if (sync_pulse)
			sync_cnt_r <= 24'h00_0000;
		else if (resync_on && ref_tick)
			sync_cnt_r <= sync_cnt_r + 24'h00_0001; // R18
	end

	// Pulses left before realignment after a new frequency
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_r <= 2'h0;
		else if (load_r0)
			pend_r <= sdm_pkg::PEND_START; // R11
		else if (sync_pulse && pend_r != 2'h0)
			pend_r <= pend_r - 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_tick     <= 1'b0;
			phase_realign <= 1'b0;
		end
		else
		begin
			sync_tick     <= sync_pulse;
			phase_realign <= sync_pulse && (pend_r == 2'h1); // R11
		end
	end

	// APB slave, zero wait states
	assign pready  = 1'b1;
	assign apb_wr  = psel && penable && pwrite;
	assign pslverr = psel && penable && !mapped;

	always_comb
	begin
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		case (paddr)
			sdm_pkg::OFS_CTRL:   rdata = {31'h0000_0000, dither_en_r};
			sdm_pkg::OFS_STATUS: rdata = {29'h0000_0000, pend_r, resync_on};
			sdm_pkg::OFS_DIVIDE: rdata = {15'h0000, interp_code, n_value};
			sdm_pkg::OFS_WORD0:  rdata = {3'h0, word0_r};
			sdm_pkg::OFS_WORD1:  rdata = {3'h0, word1_r};
			sdm_pkg::OFS_WORD2:  rdata = {3'h0, word2_r};
			sdm_pkg::OFS_WORD3:  rdata = {3'h0, word3_r};
			sdm_pkg::OFS_WORD4:  rdata = {3'h0, word4_r};
			default:             mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= rdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dither_en_r <= sdm_pkg::CTRL_RST[sdm_pkg::CTRL_DITHER];
		else if (apb_wr && paddr == sdm_pkg::OFS_CTRL)
			dither_en_r <= pwdata[sdm_pkg::CTRL_DITHER];
	end

	// Checks
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	acc_in_range_a: assert property (acc1_r < denom_eff || $changed(denom_eff)) // R01
		else $error("first accumulator not below denominator");

	step_on_ref_a: assert property (!ref_tick && !seed_now |=> $stable(acc1_r) && $stable(acc3_r)) // R03
		else $error("modulator moved without a reference edge");

	seed_load_a: assert property (load_r0 && !restart_bit && !sync_pulse |=> acc1_r == $past(seed_val) && acc2_r == 12'h000) // R06
		else $error("modulator not seeded on integer/fraction load");

	resync_gate_a: assert property (sync_tick |-> $past(resync_on)) // R07
		else $error("sync pulse while resync disabled");

	sync_interval_a: assert property (sync_pulse |-> sync_cnt_r + 24'h00_0001 == period) // R08
		else $error("sync pulse at wrong count");

	strobe_restart_a: assert property (le_rise |=> sync_cnt_r == 24'h00_0000) // R18
		else $error("timer not restarted by strobe");

	shift_in_a: assert property (sclk_rise |=> shift_r[0] == $past(sdata_s) && shift_r[28:1] == $past(shift_r[27:0])) // R14
		else $error("serial bit not shifted in");

	clkdiv_latch_a: assert property (le_rise && shift_r[2:0] == 3'h4 |=> word4_r == $past(shift_r)) // R17
		else $error("clock divider word not latched");

	realign_second_a: assert property (sync_pulse && pend_r == 2'h1 |=> phase_realign && acc1_r == $past(seed_val)) // R11
		else $error("realign missing on second sync pulse");

	dither_alive_a: assert property (dither_en_r |-> lfsr_r != 21'h0_0000) // R05
		else $error("dither sequence stuck at zero");
endmodule

// [host_serial_model.sv]
`timescale 1ns/1ns
module host_serial_model (
	// Clock
	input  wire logic pclk,
	// Serial load pins
	output logic      sclk,
	output logic      sdata,
	output logic      load_strobe
);
	initial
	begin
		sclk = 1'b0;
		sdata = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// MSB first; 6 pclk per half period keeps the clock near 10 MHz
	task automatic send(input logic [31:0] w, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			sdata <= w[i];
			hold(6);
			sclk <= 1'b1;
			hold(6);
			sclk <= 1'b0;
		end
		// Released data line shows the inverse of the last bit
		sdata <= ~w[0];
		hold(6);
		load_strobe <= 1'b1;
		hold(6);
		load_strobe <= 1'b0;
		hold(12);
	endtask
endmodule

// [fractional_sdm_phase_resync_tb_top.sv]
`timescale 1ns/1ns
module fractional_sdm_phase_resync_tb_top;
	typedef struct packed
	{
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} row_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sclk;
	logic        sdata;
	logic        load_strobe;
	logic        ref_clk = 1'b0;
	logic [12:0] n_value;
	logic [3:0]  interp_code;
	logic        sync_tick;
	logic        phase_realign;
	int          rc = 0;
	int          bad_count = 0;
	int          check_count = 0;
	row_t        rows [9] = '{
		'{1'b1, 8'h00, 32'h0000_0001, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0001, 1'b0},
		'{1'b1, 8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b1, 8'h20, 32'h0000_0001, 32'h0000_0000, 1'b1},
		'{1'b0, 8'h20, 32'h0000_0000, 32'h0000_0000, 1'b1},
		'{1'b1, 8'h0C, 32'h0000_FFFF, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0}
	};
	always #4 pclk = ~pclk;
	// Reference clock, 12 pclk period
	always @(posedge pclk)
	begin
		rc <= (rc == 5) ? 0 : rc + 1;
		if (rc == 5)
			ref_clk <= ~ref_clk;
	end
	fractional_sdm_phase_resync dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
		.phase_comparator_ref(ref_clk), .n_value(n_value), .interp_code(interp_code),
		.sync_tick(sync_tick), .phase_realign(phase_realign));
	host_serial_model host (.pclk(pclk), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (k == 20)
		begin
			bad_count++;
			end_sim;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] q);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r === q && e === 1'b0, "register read");
	endtask
	// Cycles until the next sync pulse, 500 when none comes
	task automatic wait_tick(output int n, output logic pr);
		pr = 1'b0;
		for (n = 1; n < 500; n++)
		begin
			@(posedge pclk);
			if (sync_tick === 1'b1)
				break;
		end
		pr = phase_realign;
	endtask
	initial
	begin
		#600000;
		bad_count++;
		end_sim;
	end
	initial
	begin
		logic [31:0]       r;
		logic              e;
		logic              pr;
		logic signed [3:0] c [16];
		int                s;
		int                t;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d, r, e);
			chk(e === rows[i].e && (rows[i].w || r === rows[i].q), "apb row");
		end
		host.send(32'h0000_0022, 29);
		host.send(32'h0000_0009, 29);
		host.send(32'h0000_0003, 29);
		host.send(32'h6010_0204, 31);
		rd(sdm_pkg::OFS_WORD2, 32'h0000_0022);
		rd(sdm_pkg::OFS_WORD4, 32'h0010_0204);
		rd(sdm_pkg::OFS_STATUS, 32'h0000_0001);
		host.send(32'h0032_0008, 29);
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge ref_clk);
			repeat (8) @(posedge pclk);
			c[i] = interp_code;
			chk(n_value === 13'h0064 + {{9{interp_code[3]}}, interp_code}, "n value");
		end
		s = 0;
		for (int i = 0; i < 8; i++)
		begin
			s += int'(c[i]);
			chk(c[i] === c[i + 8], "code repeat");
		end
		chk(s == 2, "code average");
		host.send(32'h0032_0008, 29);
		wait_tick(t, pr);
		chk(t > 140 && t < 210 && pr === 1'b0, "first sync");
		wait_tick(t, pr);
		chk(t == 192 && pr === 1'b1, "realign");
		host.send(32'h0000_0204, 29);
		rd(sdm_pkg::OFS_STATUS, 32'h0000_0000);
		host.send(32'h0032_0008, 29);
		wait_tick(t, pr);
		chk(t == 500, "sync while off");
		host.send(32'h0000_0FFD, 29);
		rd(sdm_pkg::OFS_WORD4, 32'h0000_0204);
		rd(sdm_pkg::OFS_WORD0, 32'h0032_0008);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(n_value === 13'h0000 && interp_code === 4'h0 && sync_tick === 1'b0
			&& phase_realign === 1'b0, "reset outputs");
		presetn <= 1'b1;
		@(posedge pclk);
		rd(sdm_pkg::OFS_WORD2, 32'h0000_0000);
		end_sim;
	end
endmodule
